// ---- core/frc_pkg.sv ----
// ****************************************************************
// Shared constants of the free running counter block.
// ****************************************************************
package counter_compare_pkg;

  // ****************************************************************
  // Register indices; the bus byte address is four times the index.
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam logic [13:0] CTRL_IDX = 14'h1880;
  localparam logic [13:0] COUNT_HIGH_IDX = 14'h1881;
  localparam logic [13:0] COUNT_LOW_IDX = 14'h1882;
  localparam logic [13:0] CMP_HIGH_IDX = 14'h1883;
  localparam logic [13:0] CMP_LOW_IDX = 14'h1884;

  // ****************************************************************
  // Field positions in counter_control_status.
  // ****************************************************************
  localparam int CLR_BIT = 7;
  localparam int RUN_BIT = 5;
  localparam int EN_BIT = 4;
  localparam int ACK_BIT = 3;
  localparam int FLAG_BIT = 2;

  // ****************************************************************
  // Values after reset, the count step and bus answer codes.
  // ****************************************************************
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- core/osc_edge_sync.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Two-stage synchroniser with a rising edge pulse.
// ****************************************************************
module osc_edge_sync (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level.
  input wire logic async_in,
  // Synchronised level and its rising edge.
  output logic level,
  output logic rise
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edge is taken between stable stages only.
  assign level = sync_r;
  assign rise = sync_r & ~last_r;

endmodule

// ---- core/free_running_counter_compare.sv ----
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// RL1 - When enabled and not halted the counter counts continuously and wraps to zero.
// RL2 - Counter reaching the compare value sets the compare flag.
// RL3 - The compare event drives its own dedicated interrupt output.
// RL4 - Compare enable bit written one enables, zero disables, reads back its state.
// RL5 - Compare logic works in every mode whenever enabled; no mode gates it.
// RL6 - Writing one to acknowledge clears the flag; zero or reading does nothing.
// RL7 - Interrupt may reassert while the count is at or above the compare value.
// RL8 - Software disables the compare interrupt right after servicing it.
// RL9 - Software rearms by clear-halt, poll, compare, ack, run, poll, enable.
// RL10 - Clear or writing run zero forces the compare enable to zero.
// RL11 - After halt, restart or clear software writes a new compare and reenables.
// RL12 - Halt never acts while clear is set; software never clears while halted.
// RL13 - Writing clear while running resets the count to zero.
// RL14 - A read shortly after clear may show a small nonzero count.
// RL15 - Lower compare address holds the upper byte, next holds the lower byte.
// RL16 - Reset zeroes enable, acknowledge and flag and loads compare with all ones.
// RL17 - Test mode counts the fast oscillator, user mode the slow oscillator.
// RL18 - Control bit 7 is a write-only clear strobe reading zero.
// RL19 - Bit 5 runs or halts, reads the analog hold, cleared only by power-on reset.
// RL20 - Bit 4 compare enable, bit 3 write-only acknowledge, bit 2 pending flag.
// RL21 - Count reads as high and low bytes and is zero after power-on.
// RL22 - Clock inputs and status levels are synchronised before the compare logic.
// RL23 - Interrupt request is high while flag and compare enable are both set.
module free_running_counter_compare
  import counter_compare_pkg::*;
(
  // Clock and resets; aresetn is the power-on reset.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset_n,
  // AXI4-Lite write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read.
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Oscillator and analog pins.
  input wire logic low_freq_osc,
  input wire logic high_freq_osc,
  input wire logic test_mode,
  input wire logic analog_hold_status,
  output logic run_enable_halt,
  // Dedicated compare interrupt.
  output logic compare_irq
);

  // ****************************************************************
  // Address decode helper.
  // ****************************************************************

  // Every mapped register index answers OKAY; anything else is refused.
  function automatic logic is_mapped(input logic [13:0] idx);
    is_mapped = (idx == CTRL_IDX) || (idx == COUNT_HIGH_IDX) || (idx == COUNT_LOW_IDX) ||
                (idx == CMP_HIGH_IDX) || (idx == CMP_LOW_IDX);
  endfunction

  logic aw_full_r;
  logic w_full_r;
  logic [13:0] aw_idx_r;
  logic [7:0] wbyte_r;
  logic lane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cmp_high;
  logic wr_cmp_low;
  logic [7:0] rd_byte;
  logic slow_rise;
  logic fast_rise;
  logic test_sync;
  logic hold_sync;
  logic tick;
  logic run_r;
  logic halt_pending_r;
  logic enable_r;
  logic flag_r;
  logic [15:0] count_r;
  logic [15:0] count_inc;
  logic [15:0] compare_r;
  logic clear_req;
  logic cmp_hit;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************

  // Counting happens on aclk; the oscillators only deliver edges.
  osc_edge_sync slow_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(low_freq_osc),
    .level(),
    .rise(slow_rise)
  ); // see RL22

  osc_edge_sync fast_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(high_freq_osc),
    .level(),
    .rise(fast_rise)
  ); // see RL22

  osc_edge_sync mode_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(test_mode),
    .level(test_sync),
    .rise()
  );

  osc_edge_sync hold_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(analog_hold_status),
    .level(hold_sync),
    .rise()
  );

  // The fast oscillator must stay below half of aclk or edges are lost.
  assign tick = test_sync ? fast_rise : slow_rise; // see RL17

  // ****************************************************************
  // AXI4-Lite write path.
  // ****************************************************************

  // Address and data are taken in either order and held until the write.
  assign awready = ~aw_full_r & ~bvalid_r;
  assign wready = ~w_full_r & ~bvalid_r;
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_ctrl = wr_fire & lane0_r & (aw_idx_r == CTRL_IDX);
  assign wr_cmp_high = wr_fire & lane0_r & (aw_idx_r == CMP_HIGH_IDX);
  assign wr_cmp_low = wr_fire & lane0_r & (aw_idx_r == CMP_LOW_IDX);
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // Write address holding register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_idx_r <= 14'h0000;
    end else if (awvalid && awready) begin
      aw_full_r <= 1'b1;
      aw_idx_r <= awaddr[ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  // Write data holding register; only byte lane 0 carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wbyte_r <= BYTE_RESET;
      lane0_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_r <= 1'b1;
      wbyte_r <= wdata[7:0];
      lane0_r <= wstrb[0];
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  // Response raised on the same edge on which the write takes effect.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read path.
  // ****************************************************************

  // Read byte selection; acknowledge and clear bits always read zero.
  always_comb begin
    rd_byte = BYTE_RESET;
    if (araddr[ADDR_W-1:2] == CTRL_IDX) begin
      rd_byte[RUN_BIT] = hold_sync; // see RL19
      rd_byte[EN_BIT] = enable_r; // see RL4
      rd_byte[FLAG_BIT] = flag_r; // see RL20
    end else if (araddr[ADDR_W-1:2] == COUNT_HIGH_IDX) begin
      rd_byte = count_r[15:8]; // see RL21
    end else if (araddr[ADDR_W-1:2] == COUNT_LOW_IDX) begin
      rd_byte = count_r[7:0]; // see RL21
    end else if (araddr[ADDR_W-1:2] == CMP_HIGH_IDX) begin
      rd_byte = compare_r[15:8];
    end else if (araddr[ADDR_W-1:2] == CMP_LOW_IDX) begin
      rd_byte = compare_r[7:0];
    end
  end

  assign arready = ~rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Reading has no side effect; a count read races the slow edge by design.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte}; // see RL14, see RL18
      rresp_r <= is_mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Run, halt and clear control.
  // ****************************************************************

  // A clear is only honoured while running.
  assign clear_req = wr_ctrl & wbyte_r[CLR_BIT] & run_r; // see RL12, see RL13

  // Of the two resets only power-on reset halts; a combined clear-halt halts one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 1'b0;
      halt_pending_r <= 1'b0;
    end else begin
      halt_pending_r <= clear_req & ~wbyte_r[RUN_BIT]; // see RL12
      if (halt_pending_r) begin
        run_r <= 1'b0;
      end else if (wr_ctrl && !(clear_req && !wbyte_r[RUN_BIT])) begin
        run_r <= wbyte_r[RUN_BIT]; // see RL19
      end
    end
  end

  assign run_enable_halt = run_r;

  // Compare enable; any clear or halt write drops it at once.
  always_ff @(posedge aclk) begin
    if (!aresetn || !soft_reset_n) begin
      enable_r <= 1'b0; // see RL16
    end else if (wr_ctrl) begin
      enable_r <= wbyte_r[EN_BIT] & wbyte_r[RUN_BIT] & ~wbyte_r[CLR_BIT]; // see RL4, see RL10
    end
  end

  // ****************************************************************
  // Counter and compare.
  // ****************************************************************

  assign count_inc = count_r + COUNT_STEP;

  // Counting is free of any power mode; only the run bit gates it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RESET; // see RL21
    end else if (clear_req) begin
      count_r <= COUNT_RESET; // see RL13
    end else if (run_r && tick) begin
      count_r <= count_inc; // see RL1, see RL5
    end
  end

  // Compare bytes, upper byte at the lower index.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_r <= COMPARE_RESET; // see RL16
    end else if (wr_cmp_high) begin
      compare_r[15:8] <= wbyte_r; // see RL15
    end else if (wr_cmp_low) begin
      compare_r[7:0] <= wbyte_r; // see RL15
    end
  end

  // Every step at or past the target re-arms the flag, so it keeps returning.
  assign cmp_hit = run_r & tick & ~clear_req & (count_inc >= compare_r); // see RL2, see RL7

  // Hardware set wins over a same-cycle acknowledge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0; // see RL16
    end else if (cmp_hit) begin
      flag_r <= 1'b1; // see RL2
    end else if (wr_ctrl && wbyte_r[ACK_BIT]) begin
      flag_r <= 1'b0; // see RL6
    end
  end

  // Dedicated request line.
  assign compare_irq = flag_r & enable_r; // see RL3, see RL23

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_count_step: assert property (run_r && tick && !clear_req |=> count_r == $past(count_inc)) // see RL1
    else $error("count did not advance by one");
  a_count_wrap: assert property (run_r && tick && !clear_req && count_r == 16'hffff |=> count_r == 16'h0000) // see RL1
    else $error("count did not wrap to zero");
  a_halted_stable: assert property (!run_r |=> $stable(count_r)) // see RL19
    else $error("count moved while halted");
  a_flag_on_hit: assert property (cmp_hit |=> flag_r) // see RL2
    else $error("flag not set on compare hit");
  a_ack_clears_flag: assert property (wr_ctrl && wbyte_r[ACK_BIT] && !cmp_hit |=> !flag_r) // see RL6
    else $error("acknowledge did not clear flag");
  a_halt_kills_enable: assert property (wr_ctrl && (!wbyte_r[RUN_BIT] || wbyte_r[CLR_BIT]) |=> !enable_r) // see RL10
    else $error("enable survived clear or halt");
  a_clear_zeroes: assert property (clear_req |=> count_r == 16'h0000) // see RL13
    else $error("clear did not zero count");
  a_clear_then_halt: assert property (clear_req && !wbyte_r[RUN_BIT] |=> run_r ##1 !run_r) // see RL12
    else $error("halt not deferred past clear");
  a_cmp_high_byte: assert property (wr_cmp_high |=> compare_r[15:8] == $past(wbyte_r)) // see RL15
    else $error("compare upper byte not written");
  a_irq_cause: assert property ($rose(compare_irq) |-> $past(cmp_hit) || $past(wr_ctrl)) // see RL23
    else $error("interrupt rose without cause");

  c_compare_hit: cover property (cmp_hit);
  c_irq_raised: cover property (compare_irq);
  c_clear_halt: cover property (clear_req ##1 halt_pending_r);
  c_wrap: cover property (run_r && tick && count_r == 16'hffff);

endmodule

// ---- test/free_running_counter_compare_bench.sv ----
`timescale 1ns/1ns
module free_running_counter_compare_bench
  import counter_compare_pkg::*;
;
  // ****************************************************************
  // Stimulus, design and bookkeeping.
  // ****************************************************************
  logic aclk = 1'b0, aresetn = 1'b0, soft_reset_n = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, run_enable_halt, compare_irq;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic low_freq_osc = 1'b0, high_freq_osc = 1'b0, test_mode = 1'b0, hold = 1'b1;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0, n_tests = 0, cycles = 0, seed = 32'h0000_8676;
  logic [7:0] cmpv;
  localparam logic [ADDR_W-1:0] A_CTRL = {CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_CNTH = {COUNT_HIGH_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_CNTL = {COUNT_LOW_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMPH = {CMP_HIGH_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMPL = {CMP_LOW_IDX, 2'b00};

  // The clock toggles every half period of 25 ns.
  always #25 aclk = ~aclk;

  free_running_counter_compare free_running_counter_compare_inst (
    .aclk(aclk), .aresetn(aresetn), .soft_reset_n(soft_reset_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'b000),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'b000),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .low_freq_osc(low_freq_osc), .high_freq_osc(high_freq_osc), .test_mode(test_mode),
    .analog_hold_status(hold), .run_enable_halt(run_enable_halt), .compare_irq(compare_irq)
  );

  // ****************************************************************
  // Checking helpers.
  // ****************************************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] expd);
    n_tests++;
    if (seen !== expd) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d.", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Control readback expected from the analog hold level, enable and flag.
  function automatic logic [33:0] cx(input logic en, input logic fl);
    return {RESP_OKAY, 24'h00_0000, 2'b00, hold, en, 1'b0, fl, 2'b00};
  endfunction

  // ****************************************************************
  // Bus master tasks; each starts one edge after the previous ends.
  // ****************************************************************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] resp);
    logic aw_done, w_done, b_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    @(posedge aclk);
    bq.push_back(resp);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_done) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        b_done = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] expd);
    logic ar_done, r_done;
    ar_done = 1'b0;
    r_done = 1'b0;
    @(posedge aclk);
    rq.push_back(expd);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_done) begin
      @(posedge aclk);
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        r_done = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask

  // Slow edges, well inside the synchroniser's reach; sel picks the fast pin.
  task automatic pulse(input int n, input logic sel);
    repeat (n) begin
      @(posedge aclk);
      if (sel) begin
        high_freq_osc <= 1'b1;
      end else begin
        low_freq_osc <= 1'b1;
      end
      repeat (4) @(posedge aclk);
      high_freq_osc <= 1'b0;
      low_freq_osc <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
  endtask

  // ****************************************************************
  // Monitor: each answer is matched against the oldest note.
  // ****************************************************************
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check({rresp, rdata}, rq.size() > 0 ? rq.pop_front() : 34'h3_ffff_ffff);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check({bresp, 32'h0000_0000}, {bq.size() > 0 ? bq.pop_front() : 2'b11, 32'h0000_0000});
    end
  end

  // A hang is cut short well above the expected run length.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      test_done();
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    cmpv = 8'h05 + 8'($unsigned($random(seed)) % 4);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // The pin synchronisers sit in reset, so the hold level needs a few edges to arrive.
    repeat (3) @(posedge aclk);
    rd(A_CTRL, cx(1'b0, 1'b0));
    rd(A_CNTH, {RESP_OKAY, 32'h0000_0000});
    rd(A_CMPH, {RESP_OKAY, 32'h0000_00ff});
    rd(A_CMPL, {RESP_OKAY, 32'h0000_00ff});
    // Unmapped place and a read-only count register.
    wr(16'h6214, 8'h55, RESP_SLVERR);
    rd(16'h6214, {RESP_SLVERR, 32'h0000_0000});
    wr(A_CNTL, 8'h77, RESP_OKAY);
    rd(A_CNTL, {RESP_OKAY, 32'h0000_0000});
    // Compare bytes land in the right halves.
    wr(A_CMPH, 8'h00, RESP_OKAY);
    wr(A_CMPL, cmpv, RESP_OKAY);
    rd(A_CMPH, {RESP_OKAY, 32'h0000_0000});
    rd(A_CMPL, {RESP_OKAY, 24'h00_0000, cmpv});
    // Count up to one below the compare value, then reach it.
    wr(A_CTRL, 8'h30, RESP_OKAY);
    check({33'h0, run_enable_halt}, 34'h1);
    pulse(int'(cmpv) - 1, 1'b0);
    rd(A_CTRL, cx(1'b1, 1'b0));
    check({33'h0, compare_irq}, 34'h0);
    pulse(1, 1'b0);
    rd(A_CNTL, {RESP_OKAY, 24'h00_0000, cmpv});
    rd(A_CTRL, cx(1'b1, 1'b1));
    check({33'h0, compare_irq}, 34'h1);
    // Acknowledge with enable off, then the flag returns at or above compare.
    wr(A_CTRL, 8'h28, RESP_OKAY);
    rd(A_CTRL, cx(1'b0, 1'b0));
    pulse(1, 1'b0);
    rd(A_CTRL, cx(1'b0, 1'b1));
    check({33'h0, compare_irq}, 34'h0);
    wr(A_CTRL, 8'h30, RESP_OKAY);
    rd(A_CTRL, cx(1'b1, 1'b1));
    // Halt forces enable off; counting stops; a clear while halted is ignored.
    wr(A_CTRL, 8'h10, RESP_OKAY);
    check({33'h0, run_enable_halt}, 34'h0);
    pulse(2, 1'b0);
    wr(A_CTRL, 8'h80, RESP_OKAY);
    rd(A_CNTL, {RESP_OKAY, 24'h00_0000, cmpv + 8'h01});
    rd(A_CTRL, cx(1'b0, 1'b1));
    // Clear while running zeroes the count and drops enable.
    wr(A_CTRL, 8'h30, RESP_OKAY);
    pulse(3, 1'b0);
    wr(A_CTRL, 8'hb0, RESP_OKAY);
    rd(A_CNTL, {RESP_OKAY, 32'h0000_0000});
    rd(A_CTRL, cx(1'b0, 1'b1));
    // Clear and halt in one write.
    pulse(2, 1'b0);
    wr(A_CTRL, 8'h80, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check({33'h0, run_enable_halt}, 34'h0);
    rd(A_CNTL, {RESP_OKAY, 32'h0000_0000});
    // The other reset clears only the enable.
    wr(A_CTRL, 8'h30, RESP_OKAY);
    @(posedge aclk);
    soft_reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    soft_reset_n <= 1'b1;
    rd(A_CTRL, cx(1'b0, 1'b1));
    check({33'h0, run_enable_halt}, 34'h1);
    rd(A_CMPL, {RESP_OKAY, 24'h00_0000, cmpv});
    // Test mode counts the fast pin only.
    test_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    pulse(2, 1'b0);
    pulse(3, 1'b1);
    rd(A_CNTL, {RESP_OKAY, 32'h0000_0003});
    test_mode <= 1'b0;
    repeat (4) @(posedge aclk);
    // Rearm the next interval in the order software must keep; the bench plays the analog hold.
    wr(A_CTRL, 8'h80, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({33'h0, run_enable_halt}, 34'h0);
    hold <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(A_CTRL, cx(1'b0, 1'b1));
    wr(A_CMPH, 8'h00, RESP_OKAY);
    wr(A_CMPL, 8'h04, RESP_OKAY);
    wr(A_CTRL, 8'h08, RESP_OKAY);
    rd(A_CTRL, cx(1'b0, 1'b0));
    wr(A_CTRL, 8'h20, RESP_OKAY);
    hold <= 1'b1;
    pulse(2, 1'b0);
    rd(A_CNTL, {RESP_OKAY, 32'h0000_0002});
    wr(A_CTRL, 8'h30, RESP_OKAY);
    pulse(2, 1'b0);
    check({33'h0, compare_irq}, 34'h1);
    wr(A_CTRL, 8'h28, RESP_OKAY);
    rd(A_CTRL, cx(1'b0, 1'b0));
    test_done();
  end
endmodule
